// >>> rtl/acss_pkg.sv
// Purpose: Shared constants for the converter configuration link
// Assumes: System clock of 40 ns on both ends
// Notes: Timing counts derive from printed times and the clock period
package acss_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 11;
  localparam int WORD_W = 16;
  localparam int REG_NUM = 32;
  localparam int CLK_PERIOD_NS = 40;
  // Least times round up, never below one cycle
  localparam int RST_PULSE_NS = 10;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int REG_WAIT_NS = 25;
  localparam int REG_WAIT_CYC = (REG_WAIT_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int SCLK_MAX_MHZ = 20;
  localparam int SCLK_SETUP_NS = 25;
  localparam int SCLK_HALF_MIN = (SCLK_SETUP_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int SCLK_HALF_DEF = 2;
  localparam int STRAP_QUAL_CYC = 16;
  // Register addresses and field positions
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_FORMAT = 5'h0a;
  localparam int BIT_PDN_OBUF = 10;
  localparam int BIT_COARSE = 9;
  localparam int BIT_CMOS = 8;
  localparam int BIT_REF_EXT = 5;
  localparam int BIT_SWRST = 4;
  localparam int BIT_STBY = 0;
  localparam int BIT_STRAIGHT = 10;
  localparam logic [10:0] REG_RESET = 11'h000;
  // Four-level strap pin codes, in fractions of analog_supply_level
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_3_8 = 2'h1;
  localparam logic [1:0] LVL_5_8 = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RST = 6'h02,
    ST_GAP = 6'h04,
    ST_SETUP = 6'h08,
    ST_SHIFT = 6'h10,
    ST_HOLD = 6'h20
  } acss_state_e;
endpackage

// >>> rtl/acss_link_if.sv
// Purpose: Pins between host controller and converter config port
// Assumes: Level codes model the four-level sensing of two pins
// Notes: All signals are driven by the host only
`timescale 1ns/1ps
interface acss_link_if;
  logic rst;             // Reset pin, high pulse or tied high
  logic config_select_n; // Active-low select
  logic sclk;            // Shift clock, also the link clock
  logic config_serial_in; // Serial data
  logic pdn;             // Power-down pin
  logic [1:0] sclk_lvl;  // Shift clock pin level code in strap mode
  logic [1:0] sel_lvl;   // Select pin level code in strap mode
  modport host (output rst, config_select_n, sclk, config_serial_in, pdn,
                sclk_lvl, sel_lvl);
  modport device (input rst, config_select_n, sclk, config_serial_in, pdn,
                  sclk_lvl, sel_lvl);
endinterface

// >>> rtl/acss_device.sv
// Purpose: Converter end: serial register writes and strap decoding
// Assumes: Level codes come from an external four-level detector
// Notes: Shifting runs on the link clock, registers on i_clk
`timescale 1ns/1ps

// What this block does
// [R1] Reset pin low: pins form serial link
// [R2] Reset pin tied high: pins set modes
// [R3] Reset pulse or soft reset loads defaults
// [R4] Shift clock level picks reference and gain
// [R5] Select level picks coding and interface
// [R6] Data and power-down pins pick power state
// [R7] Host must reset registers after start
// [R8] Shift one bit per falling edge while selected
// [R9] Commit word on every 16th falling edge
// [R10] Partial trailing word is dropped
// [R11] Word is 5 address then 11 data
// [R12] Works up to 20 MHz, any duty
// [R13] Soft reset bit self-clears after loading defaults
// [R14] Bits arrive most significant first
module acss_device (
  acss_link_if.device link,                 // Configuration pins
  input wire logic i_clk,                   // System clock
  input wire logic i_rst_n,                 // Async reset, active low
  input wire logic [4:0] i_rd_addr,         // Register to observe
  output logic [10:0] o_rd_data,            // Observed register value
  output logic o_strap_mode,                // Strap mode active
  output logic o_int_ref,                   // Internal reference in use
  output logic o_coarse_gain,               // 3.5 dB coarse gain on
  output logic o_cmos_if,                   // Parallel CMOS, else DDR LVDS
  output logic o_straight_bin,              // Straight binary coding
  output logic o_pdn_adc,                   // Converter standby
  output logic o_pdn_obuf,                  // Output buffers down
  output logic o_pdn_global                 // Reference also down
);
  // Link domain state
  logic [3:0] bit_cnt_q;
  logic [14:0] shift_q;
  logic [15:0] word_q;
  logic word_tog_q;
  // System domain state
  logic [2:0] tog_sync_q;
  logic rst_catch_q;
  logic [1:0] catch_sync_q;
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [4:0] strap_cnt_q;
  logic strap_q;
  logic [10:0] regs_q [acss_pkg::REG_NUM];

  // Bit counter cleared by select high, so trailing bits never count
  always_ff @(negedge link.sclk or posedge link.config_select_n
              or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_q <= 4'h0;
    end else if (link.config_select_n) begin
      bit_cnt_q <= 4'h0; // see [R10]
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1; // see [R9]
    end
  end

  // Shifter samples data on the falling edge, MSB first
  always_ff @(negedge link.sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_q <= 15'h0000;
    end else if (!link.config_select_n) begin
      shift_q <= {shift_q[13:0], link.config_serial_in}; // see [R8] [R14]
    end
  end

  // Whole word is held and flagged by a toggle; it stays put for
  // 16 more link edges, far longer than the crossing takes
  always_ff @(negedge link.sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_q <= 16'h0000;
      word_tog_q <= 1'b0;
    end else if (!link.config_select_n && bit_cnt_q == 4'hf) begin
      word_q <= {shift_q, link.config_serial_in}; // see [R9] [R12]
      word_tog_q <= ~word_tog_q;
    end
  end

  // Toggle crossing into the system clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_sync_q <= 3'h0;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], word_tog_q};
    end
  end

  wire word_ev = tog_sync_q[2] ^ tog_sync_q[1];

  // Reset pulse may be as short as 10 ns, so it sets a catch flop
  // asynchronously; the system side clears it once seen
  always_ff @(posedge i_clk or negedge i_rst_n or posedge link.rst) begin
    if (!i_rst_n) begin
      rst_catch_q <= 1'b0;
    end else if (link.rst) begin
      rst_catch_q <= 1'b1; // see [R3]
    end else if (catch_sync_q[1]) begin
      rst_catch_q <= 1'b0;
    end
  end

  // Two-stage synchronisers for the catch and the static pins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      catch_sync_q <= 2'h0;
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      catch_sync_q <= {catch_sync_q[0], rst_catch_q};
      pin_s1_q <= {link.rst, link.config_serial_in, link.pdn,
                   link.sclk_lvl, link.sel_lvl};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire rst_lvl = pin_s2_q[6];
  wire strap_data = pin_s2_q[5];
  wire strap_pdn = pin_s2_q[4];
  wire [1:0] sclk_lvl = pin_s2_q[3:2];
  wire [1:0] sel_lvl = pin_s2_q[1:0];

  // Strap mode needs the reset pin high for a while, so a short
  // hardware reset pulse is not taken for a tied pin
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_q <= 5'h00;
      strap_q <= 1'b0;
    end else if (!rst_lvl) begin
      strap_cnt_q <= 5'h00;
      strap_q <= 1'b0; // see [R1]
    end else if (strap_cnt_q == 5'(acss_pkg::STRAP_QUAL_CYC - 1)) begin
      strap_q <= 1'b1; // see [R2]
    end else begin
      strap_cnt_q <= strap_cnt_q + 5'h01;
    end
  end

  // Word decode; link writes count only outside strap mode
  wire [4:0] wr_addr = word_q[15:11]; // see [R11]
  wire [10:0] wr_data = word_q[10:0];
  wire wr_en = word_ev && !strap_q; // see [R1]
  wire soft_rst = wr_en && wr_addr == acss_pkg::ADDR_CTRL &&
                  wr_data[acss_pkg::BIT_SWRST];
  wire hw_rst = catch_sync_q[1];

  // Register file; the soft reset bit is never stored, so it reads 0
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < acss_pkg::REG_NUM; i++) begin
        regs_q[i] <= acss_pkg::REG_RESET;
      end
    end else if (hw_rst || soft_rst) begin
      for (int i = 0; i < acss_pkg::REG_NUM; i++) begin
        regs_q[i] <= acss_pkg::REG_RESET; // see [R3] [R13]
      end
    end else if (wr_en) begin
      regs_q[wr_addr] <= wr_data; // see [R9]
    end
  end

  // Serial mode settings from the register fields
  wire [10:0] ctrl = regs_q[acss_pkg::ADDR_CTRL];
  wire [10:0] fmt = regs_q[acss_pkg::ADDR_FORMAT];

  // Strap decode of the four-level and two-level pins
  wire s_int_ref = sclk_lvl == acss_pkg::LVL_ZERO ||
                   sclk_lvl == acss_pkg::LVL_FULL; // see [R4]
  wire s_gain = sclk_lvl == acss_pkg::LVL_5_8 ||
                sclk_lvl == acss_pkg::LVL_FULL; // see [R4]
  wire s_cmos = sel_lvl == acss_pkg::LVL_5_8 ||
                sel_lvl == acss_pkg::LVL_FULL; // see [R5]
  wire s_sbin = sel_lvl == acss_pkg::LVL_3_8 ||
                sel_lvl == acss_pkg::LVL_5_8; // see [R5]
  wire s_pdn_adc = strap_pdn; // see [R6]
  wire s_pdn_obuf = strap_data; // see [R6]
  wire s_global = strap_data && strap_pdn; // see [R6]

  // Mode select feeding the output flops
  wire int_ref_d = strap_q ? s_int_ref : !ctrl[acss_pkg::BIT_REF_EXT];
  wire gain_d = strap_q ? s_gain : ctrl[acss_pkg::BIT_COARSE];
  wire cmos_d = strap_q ? s_cmos : ctrl[acss_pkg::BIT_CMOS];
  wire sbin_d = strap_q ? s_sbin : fmt[acss_pkg::BIT_STRAIGHT];
  wire pdn_adc_d = strap_q ? s_pdn_adc : ctrl[acss_pkg::BIT_STBY];
  wire pdn_obuf_d = strap_q ? s_pdn_obuf : ctrl[acss_pkg::BIT_PDN_OBUF];
  wire global_d = strap_q && s_global;

  // All outputs registered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 11'h000;
      o_strap_mode <= 1'b0;
      o_int_ref <= 1'b1;
      o_coarse_gain <= 1'b0;
      o_cmos_if <= 1'b0;
      o_straight_bin <= 1'b0;
      o_pdn_adc <= 1'b0;
      o_pdn_obuf <= 1'b0;
      o_pdn_global <= 1'b0;
    end else begin
      o_rd_data <= regs_q[i_rd_addr];
      o_strap_mode <= strap_q;
      o_int_ref <= int_ref_d;
      o_coarse_gain <= gain_d;
      o_cmos_if <= cmos_d;
      o_straight_bin <= sbin_d;
      o_pdn_adc <= pdn_adc_d || global_d;
      o_pdn_obuf <= pdn_obuf_d;
      o_pdn_global <= global_d;
    end
  end
endmodule // acss_device

// >>> rtl/acss_host.sv
// Purpose: Host end: drives reset pulses and 16-bit serial writes
// Assumes: Shift clock made by dividing i_clk
// Notes: One word per select period; strap levels passed through
`timescale 1ns/1ps
module acss_host #(
  parameter int SCLK_HALF = acss_pkg::SCLK_HALF_DEF // i_clk per half
) (
  acss_link_if.host link,                   // Configuration pins
  input wire logic i_clk,                   // System clock
  input wire logic i_rst_n,                 // Async reset, active low
  input wire logic i_strap_mode,            // Tie reset pin high
  input wire logic [1:0] i_strap_sclk_lvl,  // Reference and gain code
  input wire logic [1:0] i_strap_sel_lvl,   // Coding and interface code
  input wire logic i_strap_data,            // Data pin level in strap
  input wire logic i_strap_pdn,             // Power-down pin level
  input wire logic i_hw_reset,              // Request reset pulse
  input wire logic i_wr_req,                // Request register write
  input wire logic [4:0] i_wr_addr,         // Register address
  input wire logic [10:0] i_wr_data,        // Register data
  output logic o_busy,                      // Sequence in progress
  output logic o_done                       // One-cycle end pulse
);
  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
  acss_pkg::acss_state_e st_q;
  logic [7:0] div_q;
  logic [4:0] bit_q;
  logic [15:0] sr_q;
  logic rst_q, sel_n_q, sclk_q, config_serial_in_q, pdn_q;
  logic [1:0] sclk_lvl_q, sel_lvl_q;

  // Pins straight from flops
  assign link.rst = rst_q;
  assign link.config_select_n = sel_n_q;
  assign link.sclk = sclk_q;
  assign link.config_serial_in = config_serial_in_q;
  assign link.pdn = pdn_q;
  assign link.sclk_lvl = sclk_lvl_q;
  assign link.sel_lvl = sel_lvl_q;

  wire tick = div_q == 8'h00;
  wire last_bit = bit_q == 5'(acss_pkg::WORD_W);
  wire idle = st_q == acss_pkg::ST_IDLE;

  // Strap levels; config_serial_in doubles as a level pin in strap mode
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pdn_q <= 1'b0;
      sclk_lvl_q <= 2'h0;
      sel_lvl_q <= 2'h0;
    end else begin
      pdn_q <= i_strap_mode & i_strap_pdn; // see [R2]
      sclk_lvl_q <= i_strap_sclk_lvl;
      sel_lvl_q <= i_strap_sel_lvl;
    end
  end

  // Sequencer: reset pulse, or one word clocked out MSB first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= acss_pkg::ST_IDLE;
      div_q <= 8'h00;
      bit_q <= 5'h00;
      sr_q <= 16'h0000;
      rst_q <= 1'b0;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b1;
      config_serial_in_q <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!tick) begin
        div_q <= div_q - 8'h01;
      end
      case (st_q)
        acss_pkg::ST_IDLE: begin
          rst_q <= i_strap_mode; // see [R1] [R2]
          config_serial_in_q <= i_strap_mode & i_strap_data;
          if (i_strap_mode) begin
            o_busy <= 1'b0;
          end else if (i_hw_reset) begin
            rst_q <= 1'b1; // see [R7]
            div_q <= 8'(acss_pkg::RST_PULSE_CYC - 1);
            o_busy <= 1'b1;
            st_q <= acss_pkg::ST_RST;
          end else if (i_wr_req) begin
            sr_q <= {i_wr_addr, i_wr_data}; // see [R11]
            config_serial_in_q <= i_wr_addr[4]; // see [R14]
            sel_n_q <= 1'b0;
            bit_q <= 5'h00;
            div_q <= HALF_M1;
            o_busy <= 1'b1;
            st_q <= acss_pkg::ST_SETUP;
          end
        end
        acss_pkg::ST_RST: begin
          if (tick) begin
            rst_q <= 1'b0;
            div_q <= 8'(acss_pkg::REG_WAIT_CYC - 1);
            st_q <= acss_pkg::ST_GAP;
          end
        end
        acss_pkg::ST_SETUP: begin
          if (tick) begin
            sclk_q <= 1'b0; // see [R8]
            bit_q <= bit_q + 5'h01;
            div_q <= HALF_M1;
            st_q <= acss_pkg::ST_SHIFT;
          end
        end
        acss_pkg::ST_SHIFT: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            div_q <= HALF_M1; // see [R12]
            if (last_bit) begin
              st_q <= acss_pkg::ST_HOLD; // see [R9]
            end else begin
              sr_q <= {sr_q[14:0], 1'b0};
              config_serial_in_q <= sr_q[14]; // see [R14]
            end
          end else if (tick) begin
            sclk_q <= 1'b0;
            bit_q <= bit_q + 5'h01;
            div_q <= HALF_M1;
          end
        end
        acss_pkg::ST_HOLD,
        acss_pkg::ST_GAP: begin
          if (tick) begin
            sel_n_q <= 1'b1;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            st_q <= acss_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= acss_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule // acss_host

// >>> bench/acss_assertions.sv
// Purpose: Checks the host-driven link pins on the system clock
// Assumes: Host built with the default two-cycle shift clock half
// Notes: Pins are sampled on i_clk, the host launches them from it
`timescale 1ns/1ps
module acss_link_assertions (
  input wire logic i_clk,            // System clock
  input wire logic i_rst_n,          // Async reset, active low
  input wire logic rst,              // Reset pin
  input wire logic config_select_n,  // Active-low select
  input wire logic sclk,             // Shift clock
  input wire logic config_serial_in, // Serial data
  input wire logic pdn,              // Power-down pin
  input wire logic [1:0] sclk_lvl,   // Strap level code, unused
  input wire logic [1:0] sel_lvl     // Strap level code, unused
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic sclk_q;
  logic [5:0] falls_q;
  // Falls per select; cleared while deselected so words never merge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b1;
      falls_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      if (config_select_n) begin
        falls_q <= 6'h00;
      end else if (sclk_q && !sclk) begin
        falls_q <= falls_q + 6'h01;
      end
    end
  end
  sclk_idle_a: assert property (
    config_select_n && !rst |-> sclk) else $error("clock not idle high");
  data_hold_a: assert property (
    !sclk && !rst |-> $stable(config_serial_in))
    else $error("data moved while clock low");
  sclk_period_a: assert property (
    $fell(sclk) && !rst |-> !sclk [*2] ##1 sclk)
    else $error("clock low phase wrong");
  word_len_a: assert property (
    $rose(config_select_n) && !rst |-> falls_q == 6'h10)
    else $error("select period not one whole word");
  sel_setup_a: assert property (
    $fell(config_select_n) |-> sclk ##1 sclk)
    else $error("select to clock setup short");
  no_sel_rst_a: assert property (
    !config_select_n |-> !rst) else $error("select while reset pin high");
  rst_gap_a: assert property (
    $fell(rst) |-> config_select_n [*2]) else $error("write too soon");
  pdn_low_a: assert property (
    !rst |-> !pdn) else $error("power-down pin high in serial mode");
  // Main scenarios reached
  word_c: cover property ($rose(config_select_n));
  pulse_c: cover property ($rose(rst) ##1 !rst);
  strap_c: cover property (rst [*8]);
endmodule // acss_link_assertions

// >>> bench/acss_test.sv
// Purpose: Drives host and device ends joined by the link
// Assumes: A second device takes bench-made multi-word frames
// Notes: Register waits poll under a bound of 40 cycles
`timescale 1ns/1ps
module acss_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic strap = 1'b0;
  logic s_data = 1'b0;
  logic s_pdn = 1'b0;
  logic hw = 1'b0;
  logic wr = 1'b0;
  logic [1:0] s_lvl = 2'h0;
  logic [4:0] wr_addr = 5'h00;
  logic [4:0] rd_addr = 5'h00;
  logic [10:0] wr_data = 11'h000;
  logic [10:0] rd_a;
  logic [10:0] rd_b;
  wire [6:0] flags;
  logic strap_on;
  logic busy;
  logic done;
  int errors = 0;
  int compares = 0;
  acss_link_if link_a();
  acss_link_if link_b();
  always #20 i_clk = ~i_clk;
  // Both ends face each other; strap levels share one code
  acss_host i_acss_host (.link(link_a.host), .i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_strap_mode(strap), .i_strap_sclk_lvl(s_lvl),
    .i_strap_sel_lvl(s_lvl), .i_strap_data(s_data), .i_strap_pdn(s_pdn),
    .i_hw_reset(hw), .i_wr_req(wr), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_busy(busy), .o_done(done));
  acss_device i_acss_device (.link(link_a.device), .i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_rd_addr(rd_addr), .o_rd_data(rd_a),
    .o_strap_mode(strap_on), .o_int_ref(flags[6]),
    .o_coarse_gain(flags[5]), .o_cmos_if(flags[4]),
    .o_straight_bin(flags[3]), .o_pdn_adc(flags[2]),
    .o_pdn_obuf(flags[1]), .o_pdn_global(flags[0]));
  // Second device, fed by the bench to reach multi-word frames
  acss_device i_acss_device_b (.link(link_b.device), .i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_rd_addr(rd_addr), .o_rd_data(rd_b),
    .o_strap_mode(), .o_int_ref(), .o_coarse_gain(), .o_cmos_if(),
    .o_straight_bin(), .o_pdn_adc(), .o_pdn_obuf(), .o_pdn_global());
  acss_link_assertions i_acss_link_assertions (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .rst(link_a.rst),
    .config_select_n(link_a.config_select_n), .sclk(link_a.sclk),
    .config_serial_in(link_a.config_serial_in), .pdn(link_a.pdn),
    .sclk_lvl(link_a.sclk_lvl), .sel_lvl(link_a.sel_lvl));
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One host request; hw selects a reset pulse over a write
  task automatic host_op(input logic h, input logic [4:0] a,
                         input logic [10:0] d);
    int n;
    @(negedge i_clk);
    hw = h;
    wr = !h;
    wr_addr = a;
    wr_data = d;
    @(negedge i_clk);
    hw = 1'b0;
    wr = 1'b0;
    chk({10'h000, busy}, 11'h001);
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      $display("wrong value at %0t: host never done", $time);
      summarize();
    end
    chk({10'h000, busy}, 11'h000);
  endtask
  // Polls because the write crosses from the link clock
  task automatic chk_reg(input logic b, input logic [4:0] a,
                         input logic [10:0] exp);
    int n;
    logic [10:0] got;
    @(negedge i_clk);
    rd_addr = a;
    n = 0;
    do begin
      @(negedge i_clk);
      got = b ? rd_b : rd_a;
      n++;
    end while (got !== exp && n < 40);
    chk(got, exp);
    // Only a used-up poll leaves a mismatch here
    if (got !== exp) begin
      summarize();
    end else begin
      repeat (2) @(negedge i_clk);
    end
  endtask
  // Bench-made frame at 125 ns; clock stands high outside it
  // Low phase lo picks the duty, the period stays 125 ns
  task automatic frame_b(input logic [46:0] v, input int n,
                         input realtime lo);
    int i;
    link_b.config_select_n = 1'b0;
    #62.5;
    for (i = n - 1; i >= 0; i--) begin
      link_b.config_serial_in = v[i];
      #(125.0 - lo);
      link_b.sclk = 1'b0;
      #lo;
      link_b.sclk = 1'b1;
    end
    #62.5;
    link_b.config_select_n = 1'b1;
    link_b.config_serial_in = ~link_b.config_serial_in;
  endtask
  // Registers are initialised by a pulse before the first write
  task automatic t_hw_reset();
    host_op(1'b1, 5'h00, 11'h000);
    host_op(1'b0, 5'h02, 11'h7ff);
    chk_reg(1'b0, 5'h02, 11'h7ff);
    host_op(1'b1, 5'h00, 11'h000);
    chk_reg(1'b0, 5'h02, 11'h000);
    chk({4'h0, flags}, 11'h040);
  endtask
  task automatic t_serial_map();
    host_op(1'b0, 5'h1f, 11'h555);
    chk_reg(1'b0, 5'h1f, 11'h555);
    host_op(1'b0, 5'h00, 11'h721);
    chk_reg(1'b0, 5'h00, 11'h721);
    chk({4'h0, flags}, 11'h036);
    host_op(1'b0, 5'h0a, 11'h400);
    chk_reg(1'b0, 5'h0a, 11'h400);
    chk({4'h0, flags}, 11'h03e);
  endtask
  // Soft reset bit clears everything and is never kept
  task automatic t_soft_reset();
    host_op(1'b0, 5'h00, 11'h010);
    chk_reg(1'b0, 5'h00, 11'h000);
    chk_reg(1'b0, 5'h0a, 11'h000);
    chk_reg(1'b0, 5'h1f, 11'h000);
    chk({4'h0, flags}, 11'h040);
  endtask
  task automatic t_strap();
    logic [6:0] exp [4] = '{7'h40, 7'h0c, 7'h3a, 7'h77};
    int i;
    for (i = 0; i < 4; i++) begin
      @(negedge i_clk);
      strap = 1'b1;
      s_lvl = i[1:0];
      s_data = i[1];
      s_pdn = i[0];
      repeat (40) @(negedge i_clk);
      chk({4'h0, flags}, {4'h0, exp[i]});
      chk({10'h000, strap_on}, 11'h001);
    end
    strap = 1'b0;
    s_lvl = 2'h0;
    s_data = 1'b0;
    s_pdn = 1'b0;
    repeat (40) @(negedge i_clk);
    chk({10'h000, strap_on}, 11'h000);
    host_op(1'b1, 5'h00, 11'h000);
  endtask
  // Two words, then a word one bit short, in one select period;
  // the last frame runs a 25 ns low phase to test uneven duty
  task automatic t_multi_word();
    @(negedge i_clk);
    link_b.rst = 1'b1;
    #20;
    link_b.rst = 1'b0;
    #30;
    frame_b({5'h03, 11'h7a5, 5'h1f, 11'h0f0, 5'h05, 10'h3ff}, 47,
            62.5);
    chk_reg(1'b1, 5'h03, 11'h7a5);
    chk_reg(1'b1, 5'h1f, 11'h0f0);
    chk_reg(1'b1, 5'h05, 11'h000);
    frame_b({31'h0, 5'h05, 11'h123}, 16, 25.0);
    chk_reg(1'b1, 5'h05, 11'h123);
  endtask
  initial begin
    link_b.rst = 1'b0;
    link_b.config_select_n = 1'b1;
    link_b.sclk = 1'b1;
    link_b.config_serial_in = 1'b0;
    link_b.pdn = 1'b0;
    link_b.sclk_lvl = 2'h0;
    link_b.sel_lvl = 2'h0;
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    t_hw_reset();
    t_serial_map();
    t_soft_reset();
    t_strap();
    t_multi_word();
    summarize();
  end
endmodule // acss_test
